// ### bsa_pkg.sv
// Package with constants and types for the BCD successive-approximation controller.
package bsa_pkg;
	localparam int DIGITS = 4;
	localparam int TRIALS_PER_DIGIT = 4;
	localparam int DECISIONS = DIGITS * TRIALS_PER_DIGIT;
	localparam logic [3:0] MSB_WEIGHT = 4'h8;
	localparam logic [3:0] DIGIT_RESET = 4'h0;
	localparam int CLOCK_HZ = 25000000;
	localparam int SETTLE_NS = 2000;
	localparam int SETTLE_CYCLES_RAW = (SETTLE_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
	localparam int SETTLE_CYCLES = (SETTLE_CYCLES_RAW < 1) ? 1 : SETTLE_CYCLES_RAW;
	localparam int READING_NS = 1000000;
	localparam int READING_CYCLES = READING_NS * (CLOCK_HZ / 1000000) / 1000;
	typedef enum logic [1:0] {
		bsa_idle,
		bsa_settle,
		bsa_decide
	} bsa_state_t;
endpackage : bsa_pkg

// ### bsa_trial_if.sv
// Interface carrying trial state between the sequencer and the digit store.
`timescale 1ns/1ps
interface bsa_trial_if;
	logic clear;
	logic keep;
	logic step;
	logic [1:0] digit;
	logic [3:0] weight;
	logic [15:0] kept;
	modport seq (output clear, output keep, output step, output digit, output weight, input kept);
	modport store (input clear, input keep, input step, input digit, input weight, output kept);
endinterface : bsa_trial_if

// ### bsa_digit_store.sv
// Register store of the retained BCD weights of every digit.
`timescale 1ns/1ps
module bsa_digit_store (
	input wire logic clock,
	input wire logic rst,
	bsa_trial_if.store t
);
	logic [3:0] digit_q [0:3];

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gen_digit
			wire logic sel = (t.digit == 2'(g));
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					digit_q[g] <= bsa_pkg::DIGIT_RESET;
				end else if (t.clear) begin
					digit_q[g] <= bsa_pkg::DIGIT_RESET;
				end else if (t.step && sel && t.keep) begin
					digit_q[g] <= digit_q[g] | t.weight;
				end
			end
			assign t.kept[15 - 4 * g -: 4] = digit_q[g];
		end
	endgenerate
endmodule : bsa_digit_store

// ### bsa_control.sv
// Top of the BCD successive-approximation conversion controller.
`timescale 1ns/1ps
// Notes on behaviour
// - Each digit takes four trials, weights 8, 4, 2, 1 in that order.
// - Comparator high drops the trial weight; otherwise it stays and accumulates.
// - After four trials move to next lower decade digit.
// - Four digits of four trials: sixteen decisions, one at a time.
// - Top digit may hold any sum up to fifteen, reading up to 15999.
// - Digits resolved serially from the top; kept weights frozen afterwards.
// - Converter code always equals kept weights plus current trial.
// - After last decision the whole reading goes to the readout.
// - Decision rate only limited by settling time; result unaffected.
// - Sequencing supports one thousand readings per second.
module bsa_control #(
	parameter int SETTLE = bsa_pkg::SETTLE_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic start,
	input wire logic cmp_above,
	output logic [15:0] dac_code,
	output logic [15:0] reading,
	output logic busy,
	output logic done
);
	bsa_trial_if t ();

	bsa_digit_store u_store (
		.clock(clock),
		.rst(rst),
		.t(t)
	);

	logic cmp_meta;
	logic cmp_sync;
	bsa_pkg::bsa_state_t state;
	bsa_pkg::bsa_state_t next_state;
	logic [1:0] digit;
	logic [3:0] weight;
	logic [15:0] settle_cnt;
	logic [15:0] held_cnt;
	logic [4:0] dec_cnt;

	// Places a four-bit weight into the nibble of one digit, the top digit at the high end.
	function automatic logic [15:0] place_weight(input logic [1:0] pos, input logic [3:0] w);
		logic [15:0] code;
		code = {w, 12'h000} >> (4 * pos);
		return code;
	endfunction : place_weight

	// Two-stage synchroniser for the analog comparator output.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cmp_meta <= 1'b0;
			cmp_sync <= 1'b0;
		end else begin
			cmp_meta <= cmp_above;
			cmp_sync <= cmp_meta;
		end
	end

	wire logic settled = (settle_cnt == 16'(SETTLE - 1));
	wire logic last_trial = (weight == 4'h1);
	wire logic last_digit = (digit == 2'(bsa_pkg::DIGITS - 1));
	wire logic deciding = (state == bsa_pkg::bsa_decide);
	wire logic finishing = deciding && last_trial && last_digit;
	// The decision reads the second synchroniser stage, so settling must cover two cycles of delay as well.
	wire logic keep_now = !cmp_sync;
	wire logic [15:0] trial_bits = place_weight(digit, weight);
	wire logic [15:0] next_dac = t.kept | trial_bits;
	// The next decade restarts at weight eight; the wrap past the last digit is never used.
	wire logic [15:0] next_top = place_weight(digit + 2'h1, bsa_pkg::MSB_WEIGHT);
	wire logic [15:0] upper_mask = ~(16'hffff >> (4 * digit));
	wire logic settling = (state == bsa_pkg::bsa_settle);

	// Trial state shared with the digit store.
	assign t.clear = (state == bsa_pkg::bsa_idle) && start;
	assign t.step = deciding;
	assign t.keep = keep_now;
	assign t.digit = digit;
	assign t.weight = weight;

	always_comb begin
		next_state = state;
		case (state)
			bsa_pkg::bsa_idle: begin
				if (start) begin
					next_state = bsa_pkg::bsa_settle;
				end
			end
			bsa_pkg::bsa_settle: begin
				if (settled) begin
					next_state = bsa_pkg::bsa_decide;
				end
			end
			bsa_pkg::bsa_decide: begin
				next_state = finishing ? bsa_pkg::bsa_idle : bsa_pkg::bsa_settle;
			end
			default: begin
				next_state = bsa_pkg::bsa_idle;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= bsa_pkg::bsa_idle;
		end else begin
			state <= next_state;
		end
	end

	// Settling counter restarts for every new trial code.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			settle_cnt <= 16'h0000;
		end else if (state != bsa_pkg::bsa_settle) begin
			settle_cnt <= 16'h0000;
		end else if (!settled) begin
			settle_cnt <= settle_cnt + 16'h0001;
		end
	end

	// Trial weight walks 8, 4, 2, 1 and then steps down one decade.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			digit <= 2'h0;
			weight <= 4'h0;
		end else if (t.clear) begin
			digit <= 2'h0;
			weight <= bsa_pkg::MSB_WEIGHT;
		end else if (deciding) begin
			if (last_trial) begin
				digit <= finishing ? 2'h0 : digit + 2'h1;
				weight <= finishing ? 4'h0 : bsa_pkg::MSB_WEIGHT;
			end else begin
				weight <= weight >> 1;
			end
		end
	end

	// The converter sees kept weights plus the trial; the top digit may reach fifteen.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dac_code <= 16'h0000;
		end else if (t.clear) begin
			dac_code <= {bsa_pkg::MSB_WEIGHT, 12'h000};
		end else if (deciding) begin
			if (finishing) begin
				dac_code <= keep_now ? (t.kept | trial_bits) : t.kept;
			end else if (last_trial) begin
				dac_code <= (keep_now ? (t.kept | trial_bits) : t.kept) | next_top;
			end else begin
				dac_code <= (keep_now ? next_dac : t.kept) | (trial_bits >> 1);
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			reading <= 16'h0000;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= finishing;
			if (finishing) begin
				reading <= keep_now ? next_dac : t.kept;
				busy <= 1'b0;
			end else if (t.clear) begin
				busy <= 1'b1;
			end
		end
	end

	// Elapsed length of the current conversion, used to check the reading rate.
	logic [31:0] conv_cycles;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			conv_cycles <= 32'h0;
		end else if (t.clear) begin
			conv_cycles <= 32'h1;
		end else if (busy) begin
			conv_cycles <= conv_cycles + 32'h1;
		end
	end

	// Helper counts for the checks below: cycles held in the current settle and decisions made so far.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			held_cnt <= 16'h0000;
		end else if (settling) begin
			held_cnt <= held_cnt + 16'h0001;
		end else begin
			held_cnt <= 16'h0000;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dec_cnt <= 5'h00;
		end else if (t.clear) begin
			dec_cnt <= 5'h00;
		end else if (deciding) begin
			dec_cnt <= dec_cnt + 5'h01;
		end
	end

	// Named steps of one conversion, from the accepted start to the transfer of the reading.
	sequence s_start_taken;
		!busy && start;
	endsequence
	sequence s_top_trial;
		busy && dac_code == 16'h8000 && t.kept == 16'h0000;
	endsequence
	sequence s_last_decision;
		deciding && last_trial && last_digit;
	endsequence
	sequence s_reading_out;
		done && !busy && reading == dac_code;
	endsequence

	// Start, busy and done handshake.
	a_done_clears_busy: assert property (@(posedge clock) disable iff (rst) done |-> !busy)
		else $error("busy still high at done");
	a_start_sets_busy: assert property (@(posedge clock) disable iff (rst)
		s_start_taken |=> s_top_trial)
		else $error("start did not begin conversion at top weight");
	a_busy_hold: assert property (@(posedge clock) disable iff (rst)
		(busy && !finishing) |=> busy)
		else $error("busy dropped before the transfer");
	a_done_pulse: assert property (@(posedge clock) disable iff (rst)
		done |=> !done)
		else $error("done held longer than one cycle");
	a_idle_rest: assert property (@(posedge clock) disable iff (rst)
		!busy |-> (weight == 4'h0 && digit == 2'h0))
		else $error("trial state left over while idle");

	// Trial order, decade stepping and decision count.
	a_first_digit: assert property (@(posedge clock) disable iff (rst)
		s_start_taken |=> (digit == 2'h0 && weight == bsa_pkg::MSB_WEIGHT))
		else $error("conversion did not begin at the top digit");
	a_weight_order: assert property (@(posedge clock) disable iff (rst)
		(deciding && !last_trial) |=> weight == $past(weight) >> 1)
		else $error("trial weight did not halve");
	a_decade_step: assert property (@(posedge clock) disable iff (rst)
		(deciding && last_trial && !last_digit) |=> digit == $past(digit) + 2'h1 && weight == 4'h8)
		else $error("digit did not step a decade");
	a_one_decision: assert property (@(posedge clock) disable iff (rst)
		deciding |=> !deciding)
		else $error("two decisions in a row");
	a_sixteen_decisions: assert property (@(posedge clock) disable iff (rst)
		s_last_decision |-> dec_cnt == 5'(bsa_pkg::DECISIONS - 1))
		else $error("conversion did not take sixteen decisions");
	a_settle_wait: assert property (@(posedge clock) disable iff (rst)
		deciding |-> held_cnt == 16'(SETTLE))
		else $error("decision made before settling");
	a_rate_limit: assert property (@(posedge clock) disable iff (rst)
		busy |-> conv_cycles <= 32'(bsa_pkg::READING_CYCLES))
		else $error("conversion too slow");

	// Keep-or-reject decisions and the converter code.
	a_reject_drop: assert property (@(posedge clock) disable iff (rst)
		(deciding && cmp_sync && !finishing) |=> (dac_code & $past(trial_bits)) == 16'h0)
		else $error("rejected weight kept");
	a_keep_weight: assert property (@(posedge clock) disable iff (rst)
		(deciding && !cmp_sync) |=> (t.kept & $past(trial_bits)) == $past(trial_bits))
		else $error("accepted weight not retained");
	a_dac_sum: assert property (@(posedge clock) disable iff (rst)
		(state == bsa_pkg::bsa_settle) |-> dac_code == (t.kept | trial_bits))
		else $error("converter code not kept plus trial");
	a_idle_hold: assert property (@(posedge clock) disable iff (rst)
		(!busy && !start) |=> $stable(dac_code))
		else $error("converter code moved while idle");
	a_digit_frozen: assert property (@(posedge clock) disable iff (rst)
		busy |=> ((t.kept ^ $past(t.kept)) & $past(upper_mask)) == 16'h0000)
		else $error("a finished digit changed");

	// Transfer of the finished reading.
	a_transfer_out: assert property (@(posedge clock) disable iff (rst)
		s_last_decision |=> s_reading_out)
		else $error("reading not transferred after the last decision");
	a_readout_hold: assert property (@(posedge clock) disable iff (rst)
		!finishing |=> reading == $past(reading))
		else $error("reading changed outside transfer");
	a_top_nibble: assert property (@(posedge clock) disable iff (rst)
		s_last_decision |=> reading[15:12] == $past(t.kept[15:12]))
		else $error("top digit not passed on whole");
	a_final_reject: assert property (@(posedge clock) disable iff (rst)
		(finishing && cmp_sync) |=> (reading & $past(trial_bits)) == 16'h0000)
		else $error("last rejected weight in reading");
	a_final_keep: assert property (@(posedge clock) disable iff (rst)
		(finishing && !cmp_sync) |=> (reading & $past(trial_bits)) == $past(trial_bits))
		else $error("last accepted weight missing from reading");

	// Digits below the one on trial have had no trial yet and must still be empty.
	genvar lg;
	generate
		for (lg = 1; lg < bsa_pkg::DIGITS; lg++) begin : gen_lower_check
			a_lower_empty: assert property (@(posedge clock) disable iff (rst)
				(busy && digit < 2'(lg)) |-> t.kept[15 - 4 * lg -: 4] == 4'h0)
				else $error("lower digit set too early");
		end
	endgenerate
endmodule : bsa_control

// ### bsa_analog_model.sv
// Behavioural model of the weighted converter switches and the null-detecting comparator.
`timescale 1ns/1ps
module bsa_analog_model (
	input wire logic [15:0] dac_code,
	input wire logic [15:0] vin,
	output logic cmp_above
);
	int level;
	// The switch network sums the four decade nibbles, so a nibble may carry any weight sum up to fifteen.
	assign level = dac_code[15:12] * 1000 + dac_code[11:8] * 100 + dac_code[7:4] * 10 + dac_code[3:0];
	// A trial above the held input is flagged for rejection; an equal trial is kept.
	assign cmp_above = (level > int'(vin));
endmodule : bsa_analog_model

// ### test_bcd_successive_approx_control.sv
// Self-checking testbench of the BCD successive-approximation controller.
`timescale 1ns/1ps
module test_bcd_successive_approx_control;
	localparam int SET = 4;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic [15:0] vin = 16'h0;
	logic cmp_above;
	logic [15:0] dac_code;
	logic [15:0] reading;
	logic busy;
	logic done;
	int error_cnt = 0;
	int n_tests = 0;
	int corners[8] = '{0, 1, 5555, 9999, 10000, 14999, 15000, 15999};

	always #20 clock = ~clock;

	bsa_control #(.SETTLE(SET)) dut (.clock(clock), .rst(rst), .start(start), .cmp_above(cmp_above),
		.dac_code(dac_code), .reading(reading), .busy(busy), .done(done));
	bsa_analog_model far (.dac_code(dac_code), .vin(vin), .cmp_above(cmp_above));

	function automatic logic [15:0] to_bcd(input int v);
		return {4'(v / 1000), 4'((v / 100) % 10), 4'((v / 10) % 10), 4'(v % 10)};
	endfunction : to_bcd

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report;
		$display("checks %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	// A second start pulse during a conversion must not disturb it.
	task automatic convert(input int v, input bit poke);
		int n;
		logic [15:0] prev;
		prev = reading;
		@(posedge clock);
		vin <= 16'(v);
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		#1;
		check({15'h0, busy}, 16'h1);
		check(dac_code, 16'h8000);
		for (n = 0; n < 400; n++) begin
			@(posedge clock);
			start <= (poke && n == 10);
			#1;
			if (done === 1'b1)
				break;
			check(reading, prev);
		end
		check(16'(n + 1), 16'(bsa_pkg::DECISIONS * (SET + 1)));
		check({15'h0, done}, 16'h1);
		check(reading, to_bcd(v));
		check(dac_code, to_bcd(v));
		check({15'h0, busy}, 16'h0);
		@(posedge clock);
		#1;
		check({15'h0, done}, 16'h0);
		check(reading, to_bcd(v));
	endtask : convert

	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		final_report();
	end

	initial begin
		void'($urandom(32'h346e));
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		foreach (corners[i])
			convert(corners[i], i[0]);
		for (int i = 0; i < 30; i++)
			convert(int'($urandom_range(15999, 0)), (i % 3) == 0);
		@(posedge clock);
		vin <= 16'h1234;
		start <= 1'b1;
		repeat (20) @(posedge clock);
		start <= 1'b0;
		rst <= 1'b1;
		#1;
		check(dac_code, 16'h0);
		check({14'h0, busy, done}, 16'h0);
		check(reading, 16'h0);
		@(posedge clock);
		rst <= 1'b0;
		convert(4660, 1'b0);
		final_report();
	end
endmodule : test_bcd_successive_approx_control
